/* serial_params.svh */
// Constants of the serial port buffer and control block
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH

// Register word indices, byte address is four times the index
`define IDX_SERIAL_CONTROL  10'h098
`define IDX_SERIAL_DATA     10'h099
`define IDX_OWN_ADDRESS     10'h0a9
`define IDX_ADDRESS_MASK    10'h0b9
`define IDX_POWER_CONTROL   10'h0c0
`define IDX_INT_STATUS      10'h0c1
`define IDX_INT_MASK        10'h0c2
`define IDX_BAUD_DIVISOR    10'h0c3
`define IDX_NONE            10'h3ff

// Reset values
`define SERIAL_CONTROL_RESET 8'h00
`define OWN_ADDRESS_RESET    8'h00
`define ADDRESS_MASK_RESET   8'h00
`define POWER_CONTROL_RESET  8'h00
`define INT_MASK_RESET       4'h0
`define BAUD_DIVISOR_RESET   16'h0364

// Field positions
`define SC_MODE_LOW   7
`define SC_MODE_HIGH  6
`define SC_MULTI      5
`define SC_RX_ENABLE  4
`define SC_TX_NINTH   3
`define SC_RX_NINTH   2
`define SC_TX_DONE    1
`define SC_RX_DONE    0
`define PC_FE_SELECT  6
`define PC_DOUBLE     7
`define INT_TX        0
`define INT_RX        1
`define INT_FE        2
`define INT_MATCH     3

// Bit times in clock cycles
`define MODE0_CYCLES      16'h000c
`define MODE2_CYCLES_SLOW 16'h0040
`define MODE2_CYCLES_FAST 16'h0020
`endif

/* serial_port_buffer_and_control.sv */
// Serial port buffer, address match and control registers on AHB-Lite
`default_nettype none
`include "serial_params.svh"
module serial_port_buffer_and_control
   import serial_types_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        rxd,
   output logic             txd,
   output logic             irq
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [7:0]  serial_control;
   logic        framing_error_flag;
   logic [7:0]  tx_buffer;
   logic [7:0]  rx_buffer;
   logic [7:0]  slave_own_address;
   logic [7:0]  slave_address_mask;
   logic [7:0]  power_control;
   logic [15:0] baud_divisor;
   logic [3:0]  int_status;
   logic [3:0]  int_mask;
   logic        tx_pending;
   logic        dp_write;
   logic        dp_read;
   logic [9:0]  dp_idx;
   logic        rxd_meta;
   logic        rxd_sync;
   logic        tx_line;
   logic        tx_busy;
   logic        tx_done;
   logic [7:0]  rx_data;
   logic        rx_ninth;
   logic        rx_stop_ok;
   logic        rx_done;

   // Match a captured word index against a register index
   function automatic logic reg_sel(input logic [9:0] idx, input logic [9:0] target);
      reg_sel = (idx == target);
   endfunction

   // ---------------------------------------------------------------
   // Bus address phase
   // ---------------------------------------------------------------
   // Only aligned words in the low 4 KB are mapped, the rest is a hole
   wire        take     = hsel & htrans[1] & hready;
   wire        in_range = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'b00);
   wire [9:0]  next_idx = in_range ? haddr[11:2] : `IDX_NONE;
   wire        hsize_ok = (hsize == 3'b010);

   // Capture the address phase; reads get one wait state
   always_ff @(posedge clk) begin
      if (!nrst) begin
         dp_write <= 1'b0;
         dp_read <= 1'b0;
         dp_idx <= `IDX_NONE;
         hreadyout <= 1'b1;
      end else begin
         dp_write <= take & hwrite & hsize_ok;
         dp_read <= take & !hwrite;
         dp_idx <= take ? next_idx : dp_idx;
         hreadyout <= !(take & !hwrite);
      end
   end

   // Every transfer answers OKAY
   always_ff @(posedge clk) begin
      hresp <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Write decode
   // ---------------------------------------------------------------
   wire [7:0] wd        = hwdata[7:0];
   wire       wr_ctrl   = dp_write & reg_sel(dp_idx, `IDX_SERIAL_CONTROL);
   wire       wr_data   = dp_write & reg_sel(dp_idx, `IDX_SERIAL_DATA);
   wire       wr_own    = dp_write & reg_sel(dp_idx, `IDX_OWN_ADDRESS);
   wire       wr_mask   = dp_write & reg_sel(dp_idx, `IDX_ADDRESS_MASK);
   wire       wr_power  = dp_write & reg_sel(dp_idx, `IDX_POWER_CONTROL);
   wire       wr_status = dp_write & reg_sel(dp_idx, `IDX_INT_STATUS);
   wire       wr_imask  = dp_write & reg_sel(dp_idx, `IDX_INT_MASK);
   wire       wr_baud   = dp_write & reg_sel(dp_idx, `IDX_BAUD_DIVISOR);

   // ---------------------------------------------------------------
   // Mode selection and bit timing
   // ---------------------------------------------------------------
   // The stored mode-low bit keeps steering the mode even while bit 7 reads FE
   wire             fe_select = power_control[`PC_FE_SELECT];
   serial_mode_type mode;
   assign mode = serial_mode_type'({serial_control[`SC_MODE_LOW],
                                    serial_control[`SC_MODE_HIGH]});
   wire nine_bit  = (mode == MODE_UART9_FIXED) || (mode == MODE_UART9_VAR);
   wire framed    = (mode != MODE_SHIFT);
   wire multi     = serial_control[`SC_MULTI];
   wire rx_enable = serial_control[`SC_RX_ENABLE] & framed;

   // Bit time per mode: fixed divisions or the software divisor
   wire [15:0] fixed9_cycles = power_control[`PC_DOUBLE] ? `MODE2_CYCLES_FAST
                                                         : `MODE2_CYCLES_SLOW;
   wire [15:0] bit_cycles = (mode == MODE_SHIFT)       ? `MODE0_CYCLES :
                            (mode == MODE_UART9_FIXED) ? fixed9_cycles :
                                                         baud_divisor;

   // ---------------------------------------------------------------
   // Line input synchroniser
   // ---------------------------------------------------------------
   // Two stages before the receiver looks at the pin
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rxd_meta <= 1'b1;
         rxd_sync <= 1'b1;
      end else begin
         rxd_meta <= rxd;
         rxd_sync <= rxd_meta;
      end
   end

   // ---------------------------------------------------------------
   // Transmitter and receiver
   // ---------------------------------------------------------------
   wire tx_start = tx_pending & !tx_busy;

   serial_tx u_tx (
      .clk        (clk),
      .nrst       (nrst),
      .start      (tx_start),
      .data       (tx_buffer),
      .framed     (framed),
      .nine       (nine_bit),
      .ninth      (serial_control[`SC_TX_NINTH]),
      .bit_cycles (bit_cycles),
      .line       (tx_line),
      .busy       (tx_busy),
      .done       (tx_done)
   );

   serial_rx u_rx (
      .clk        (clk),
      .nrst       (nrst),
      .rxd        (rxd_sync),
      .enable     (rx_enable),
      .nine       (nine_bit),
      .bit_cycles (bit_cycles),
      .data       (rx_data),
      .ninth      (rx_ninth),
      .stop_ok    (rx_stop_ok),
      .done       (rx_done)
   );

   // ---------------------------------------------------------------
   // Address recognition and frame acceptance
   // ---------------------------------------------------------------
   // Mask-selected bits must agree, the others are don't-care
   wire addr_match = ((rx_data ^ slave_own_address) & slave_address_mask) == 8'h00;
   // With multiprocessor mode on, 9-bit modes keep only matching address
   // frames and the 8-bit mode keeps only frames with a good stop bit
   wire accept_ok  = !multi | (nine_bit ? (rx_ninth & addr_match) : rx_stop_ok);
   wire rx_accept  = rx_done & accept_ok;
   wire match_evt  = rx_accept & multi & nine_bit;
   wire frame_bad  = rx_done & !rx_stop_ok;
   wire rx_bit8    = nine_bit ? rx_ninth : rx_stop_ok;

   // ---------------------------------------------------------------
   // Serial control register
   // ---------------------------------------------------------------
   // Hardware sets of the done flags win over a software clear
   wire [7:0] next_serial_control;
   assign next_serial_control[`SC_MODE_LOW] =
      (wr_ctrl & !fe_select) ? wd[7] : serial_control[`SC_MODE_LOW];
   assign next_serial_control[6:3] = wr_ctrl ? wd[6:3] : serial_control[6:3];
   assign next_serial_control[`SC_RX_NINTH] =
      rx_accept ? rx_bit8 : (wr_ctrl ? wd[2] : serial_control[`SC_RX_NINTH]);
   assign next_serial_control[`SC_TX_DONE] =
      tx_done | (wr_ctrl ? wd[1] : serial_control[`SC_TX_DONE]);
   assign next_serial_control[`SC_RX_DONE] =
      rx_accept | (wr_ctrl ? wd[0] : serial_control[`SC_RX_DONE]);

   always_ff @(posedge clk) begin
      if (!nrst) serial_control <= `SERIAL_CONTROL_RESET;
      else serial_control <= next_serial_control;
   end

   // Framing error: set by a bad stop bit, cleared only by software
   wire next_framing_error = frame_bad |
      ((wr_ctrl & fe_select) ? wd[7] : framing_error_flag);

   always_ff @(posedge clk) begin
      if (!nrst) framing_error_flag <= 1'b0;
      else framing_error_flag <= next_framing_error;
   end

   // ---------------------------------------------------------------
   // Data buffers
   // ---------------------------------------------------------------
   // Buffers carry no reset; their contents are undefined until loaded
   always_ff @(posedge clk) begin
      if (wr_data) tx_buffer <= wd;
   end

   always_ff @(posedge clk) begin
      if (rx_accept) rx_buffer <= rx_data;
   end

   // A write while busy is sent once the current frame ends
   wire next_tx_pending = wr_data | (tx_pending & tx_busy);

   always_ff @(posedge clk) begin
      if (!nrst) tx_pending <= 1'b0;
      else tx_pending <= next_tx_pending;
   end

   // ---------------------------------------------------------------
   // Address, mask, power control and divisor
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         slave_own_address <= `OWN_ADDRESS_RESET;
         slave_address_mask <= `ADDRESS_MASK_RESET;
      end else begin
         if (wr_own) slave_own_address <= wd;
         if (wr_mask) slave_address_mask <= wd;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         power_control <= `POWER_CONTROL_RESET;
         baud_divisor <= `BAUD_DIVISOR_RESET;
      end else begin
         if (wr_power) power_control <= wd;
         if (wr_baud) baud_divisor <= hwdata[15:0];
      end
   end

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   // Sticky events, write one to clear, a new event wins over the clear
   wire [3:0] events;
   assign events[`INT_TX]    = tx_done;
   assign events[`INT_RX]    = rx_accept;
   assign events[`INT_FE]    = frame_bad;
   assign events[`INT_MATCH] = match_evt;
   wire [3:0] clear_bits = wr_status ? hwdata[3:0] : 4'h0;
   wire [3:0] next_int_status = events | (int_status & ~clear_bits);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         int_status <= 4'h0;
         int_mask <= `INT_MASK_RESET;
      end else begin
         int_status <= next_int_status;
         if (wr_imask) int_mask <= hwdata[3:0];
      end
   end

   // Level interrupt while any unmasked status bit is set
   always_ff @(posedge clk) begin
      if (!nrst) irq <= 1'b0;
      else irq <= |(next_int_status & int_mask);
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   // Bit 7 of the control view depends on the framing-error select
   wire [7:0] control_view = {fe_select ? framing_error_flag
                                        : serial_control[`SC_MODE_LOW],
                              serial_control[6:0]};
   wire [31:0] rd_value =
      reg_sel(dp_idx, `IDX_SERIAL_CONTROL) ? {24'h000000, control_view}       :
      reg_sel(dp_idx, `IDX_SERIAL_DATA)    ? {24'h000000, rx_buffer}          :
      reg_sel(dp_idx, `IDX_OWN_ADDRESS)    ? {24'h000000, slave_own_address}  :
      reg_sel(dp_idx, `IDX_ADDRESS_MASK)   ? {24'h000000, slave_address_mask} :
      reg_sel(dp_idx, `IDX_POWER_CONTROL)  ? {24'h000000, power_control}      :
      reg_sel(dp_idx, `IDX_INT_STATUS)     ? {28'h0000000, int_status}        :
      reg_sel(dp_idx, `IDX_INT_MASK)       ? {28'h0000000, int_mask}          :
      reg_sel(dp_idx, `IDX_BAUD_DIVISOR)   ? {16'h0000, baud_divisor}         :
                                             32'h00000000;

   // Read data is registered during the wait state
   always_ff @(posedge clk) begin
      if (!nrst) hrdata <= 32'h00000000;
      else if (dp_read) hrdata <= rd_value;
   end

   // ---------------------------------------------------------------
   // Line output
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) txd <= 1'b1;
      else txd <= tx_line;
   end

endmodule // serial_port_buffer_and_control
`default_nettype wire

/* serial_port_buffer_and_control_chk.sv */
// Checker of bus timing, reset state, flag clearing and line quiet
`default_nettype none
`include "serial_params.svh"
module serial_port_chk (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic        rxd,
   input wire logic        txd,
   input wire logic        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Decode of taken transfers and of the mapped words
   wire logic [9:0] idx      = haddr[11:2];
   wire logic       taken    = hsel && htrans[1] && hready;
   wire logic       rd_taken = taken && !hwrite;
   wire logic       wr_taken = taken && hwrite;
   wire logic       in_map   = idx == `IDX_SERIAL_CONTROL || idx == `IDX_SERIAL_DATA
                               || idx == `IDX_OWN_ADDRESS || idx == `IDX_ADDRESS_MASK
                               || idx[9:2] == 8'h30;
   wire logic       mapped   = haddr[31:12] == 20'h0 && haddr[1:0] == 2'b00 && in_map;
   logic            tx_ever;
   // Remembers a data buffer write since reset
   always_ff @(posedge clk) begin
      if (!nrst) tx_ever <= 1'b0;
      else if (wr_taken && idx == `IDX_SERIAL_DATA) tx_ever <= 1'b1;
   end
   property p_rd_wait;
      rd_taken |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_wr_fast;
      wr_taken |=> hreadyout;
   endproperty
   a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
   property p_wait_cause;
      !hreadyout |-> $past(rd_taken);
   endproperty
   a_wait_cause: assert property (p_wait_cause) else $error("stray wait state");
   property p_rd_hold;
      $changed(hrdata) |-> $past(rd_taken, 2) || !$past(nrst);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved alone");
   property p_unmapped;
      rd_taken && !mapped |-> ##2 hrdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_irq_fall;
      $fell(irq) |-> $past(wr_taken, 2) || $past(wr_taken, 3) || $past(wr_taken, 4);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
   property p_tx_quiet;
      !tx_ever |-> txd;
   endproperty
   a_tx_quiet: assert property (p_tx_quiet) else $error("line left idle unasked");
   property p_reset_out;
      $rose(nrst) |-> txd && !irq && hreadyout && hrdata == 32'h0;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not in reset state");
   property p_resp_okay;
      !hresp;
   endproperty
   a_resp_okay: assert property (p_resp_okay) else $error("error response given");
endmodule // serial_port_chk
bind serial_port_buffer_and_control serial_port_chk u_chk (.clk, .nrst, .hsel, .haddr,
   .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .rxd, .txd, .irq);
`default_nettype wire

/* serial_rx.sv */
// Serial receiver with mid-bit sampling
`default_nettype none
module serial_rx
   import serial_types_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        rxd,
   input  wire logic        enable,
   input  wire logic        nine,
   input  wire logic [15:0] bit_cycles,
   output logic [7:0]       data,
   output logic             ninth,
   output logic             stop_ok,
   output logic             done
);
   rx_state_type state;
   logic [15:0]  cyc;
   logic [3:0]   idx;
   wire  [15:0]  half      = {1'b0, bit_cycles[15:1]};
   wire          bit_end   = (state == RX_START) ? (cyc == half) : (cyc == bit_cycles - 16'h0001);
   wire          last_data = nine ? (idx == 4'd8) : (idx == 4'd7);

   // Bit timer restarts on every sample
   always_ff @(posedge clk) begin
      if (!nrst) cyc <= 16'h0000;
      else cyc <= (state == RX_IDLE || bit_end) ? 16'h0000 : cyc + 16'h0001;
   end

   // Frame sequencer, start bit checked at its middle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= RX_IDLE;
         idx <= 4'd0;
         data <= 8'h00;
         ninth <= 1'b0;
         stop_ok <= 1'b1;
         done <= 1'b0;
      end else begin
         done <= (state == RX_STOP) && bit_end;
         unique case (state)
            RX_IDLE: if (enable && !rxd) state <= RX_START;
            RX_START: if (bit_end) begin
               idx <= 4'd0;
               state <= rxd ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (bit_end) begin
               idx <= idx + 4'd1;
               if (idx == 4'd8) ninth <= rxd;
               else data <= {rxd, data[7:1]};
               if (last_data) state <= RX_STOP;
            end
            RX_STOP: if (bit_end) begin
               stop_ok <= rxd;
               state <= RX_IDLE;
            end
            default: state <= RX_IDLE;
         endcase
      end
   end
endmodule // serial_rx
`default_nettype wire

/* serial_station.sv */
// Remote serial station that sends frames and captures transmitted ones
`default_nettype none
module serial_station (
   input  wire logic clk,
   input  wire logic txd,
   output var logic  rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial rxd = 1'b1; // Line idles high
   // Sends start, data LSB first, the chosen stop level, then idles
   task automatic send(input logic [8:0] bits, input int n, input logic stop, input int bc);
      rxd <= 1'b0;
      repeat (bc) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         rxd <= bits[i];
         repeat (bc) @(posedge clk);
      end
      rxd <= stop;
      repeat (bc) @(posedge clk);
      rxd <= 1'b1;
      repeat (bc) @(posedge clk); // One idle bit time so a low stop is not taken as a start
   endtask
   // Samples a frame from the device at mid-bit
   task automatic take(output logic [7:0] d, output logic stop, input int bc);
      do @(posedge clk); while (txd !== 1'b0);
      repeat (bc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (bc) @(posedge clk);
         d[i] = txd;
      end
      repeat (bc) @(posedge clk);
      stop = txd;
   endtask
endmodule // serial_station
`default_nettype wire

/* serial_tx.sv */
// Serial transmitter shift register
`default_nettype none
module serial_tx (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        start,
   input  wire logic [7:0]  data,
   input  wire logic        framed,
   input  wire logic        nine,
   input  wire logic        ninth,
   input  wire logic [15:0] bit_cycles,
   output logic             line,
   output logic             busy,
   output logic             done
);
   logic [10:0] shifter;
   logic [3:0]  bits_left;
   logic [15:0] cyc;
   wire         bit_end  = (cyc == bit_cycles - 16'h0001);
   wire  [10:0] frame    = framed ? {1'b1, nine ? ninth : 1'b1, data, 1'b0} : {3'b111, data};
   wire  [3:0]  frame_len = framed ? (nine ? 4'd11 : 4'd10) : 4'd8;
   assign line = busy ? shifter[0] : 1'b1;

   // Load a frame and shift it out one bit time per bit
   always_ff @(posedge clk) begin
      if (!nrst) begin
         shifter <= 11'h7ff;
         bits_left <= 4'd0;
         cyc <= 16'h0000;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= busy && bit_end && (bits_left == 4'd1);
         if (start && !busy) begin
            shifter <= frame;
            bits_left <= frame_len;
            cyc <= 16'h0000;
            busy <= 1'b1;
         end else if (busy) begin
            cyc <= bit_end ? 16'h0000 : cyc + 16'h0001;
            if (bit_end) begin
               shifter <= {1'b1, shifter[10:1]};
               bits_left <= bits_left - 4'd1;
               busy <= (bits_left != 4'd1);
            end
         end
      end
   end
endmodule // serial_tx
`default_nettype wire

/* serial_types_pkg.sv */
// Types of the serial port buffer and control block
`default_nettype none
package serial_types_pkg;
   typedef enum logic [1:0] {
      MODE_SHIFT = 2'b00, MODE_UART8 = 2'b01, MODE_UART9_FIXED = 2'b10, MODE_UART9_VAR = 2'b11
   } serial_mode_type;
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
   } rx_state_type;
endpackage
`default_nettype wire

/* test_serial_port_buffer_and_control.sv */
// Testbench driving the registers over AHB-Lite and the serial line
`default_nettype none
`include "serial_params.svh"
module test_serial_port_buffer_and_control import serial_types_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_CTRL = {20'h0, `IDX_SERIAL_CONTROL, 2'b00};
   localparam logic [31:0] A_DATA = {20'h0, `IDX_SERIAL_DATA, 2'b00};
   localparam logic [31:0] A_OWN  = {20'h0, `IDX_OWN_ADDRESS, 2'b00};
   localparam logic [31:0] A_MASK = {20'h0, `IDX_ADDRESS_MASK, 2'b00};
   localparam logic [31:0] A_PWR  = {20'h0, `IDX_POWER_CONTROL, 2'b00};
   localparam logic [31:0] A_STAT = {20'h0, `IDX_INT_STATUS, 2'b00};
   localparam logic [31:0] A_IMSK = {20'h0, `IDX_INT_MASK, 2'b00};
   localparam logic [31:0] A_BAUD = {20'h0, `IDX_BAUD_DIVISOR, 2'b00};
   localparam int          BC     = 16;
   localparam logic [31:0] C8     = {24'h0, MODE_UART8, 6'h10};
   logic        clk    = 1'b0;
   logic        nrst   = 1'b0;
   logic        hsel   = 1'b0;
   logic        hwrite = 1'b0;
   logic [31:0] haddr  = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize  = 3'b010;
   wire logic   hreadyout, hresp, txd, irq, rxd;
   wire logic [31:0] hrdata;
   int          err_total = 0;
   int          samples_checked = 0;
   logic [31:0] rd;
   logic [7:0]  got;
   logic        stp;
   serial_port_buffer_and_control u_dut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rxd, .txd, .irq);
   serial_station u_station (.clk, .txd, .rxd);
   initial forever #5 clk = ~clk;
   // One single transfer, read data kept in rd
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(name, rd, exp);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Cuts a hung run short
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      report_and_stop;
   end
   // Test sequence
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rdchk("control", A_CTRL, 32'h0);
      rdchk("own", A_OWN, 32'h0);
      rdchk("mask", A_MASK, 32'h0);
      $display("reset test done");
      bus(1'b1, A_OWN, 32'h5a);
      bus(1'b1, A_MASK, 32'hf0);
      bus(1'b1, 32'h400, 32'hff);
      rdchk("own", A_OWN, 32'h5a);
      rdchk("mask", A_MASK, 32'hf0);
      rdchk("unmapped", 32'h400, 32'h0);
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, A_CTRL, {24'h0, 2'(m), 6'h0});
         rdchk("mode", A_CTRL, {24'h0, 2'(m), 6'h0});
      end
      $display("register test done");
      bus(1'b1, A_BAUD, BC);
      bus(1'b1, A_IMSK, 32'h1);
      bus(1'b1, A_CTRL, {24'h0, MODE_UART8, 6'h0});
      fork
         bus(1'b1, A_DATA, 32'ha5);
         u_station.take(got, stp, BC);
      join
      check("tx data", {24'h0, got}, 32'ha5);
      check("tx stop", {31'h0, stp}, 32'h1);
      do bus(1'b0, A_CTRL, 32'h0); while (rd[`SC_TX_DONE] !== 1'b1);
      rdchk("status", A_STAT, 32'h1);
      check("irq on", {31'h0, irq}, 32'h1);
      bus(1'b1, A_IMSK, 32'h0);
      rdchk("status", A_STAT, 32'h1);
      check("irq masked", {31'h0, irq}, 32'h0);
      bus(1'b1, A_STAT, 32'h1);
      rdchk("status", A_STAT, 32'h0);
      $display("transmit test done");
      // Fixed-rate 9-bit mode at both divisions, ninth bit taken from bit 3
      for (int p = 0; p < 2; p++) begin
         bus(1'b1, A_PWR, {24'h0, p[0], 7'h0});
         bus(1'b1, A_CTRL, {24'h0, MODE_UART9_FIXED, 6'h08});
         fork
            bus(1'b1, A_DATA, 32'h3c);
            u_station.take(got, stp, p ? `MODE2_CYCLES_FAST : `MODE2_CYCLES_SLOW);
         join
         check("fixed data", {24'h0, got}, 32'h3c);
         check("ninth bit", {31'h0, stp}, 32'h1);
         do bus(1'b0, A_CTRL, 32'h0); while (rd[`SC_TX_DONE] !== 1'b1);
      end
      bus(1'b1, A_PWR, 32'h0);
      $display("fixed rate test done");
      bus(1'b1, A_CTRL, {24'h0, MODE_UART8, 6'h0});
      u_station.send(9'h03c, 8, 1'b1, BC);
      rdchk("rx off", A_CTRL, {24'h0, MODE_UART8, 6'h0});
      bus(1'b1, A_CTRL, C8);
      u_station.send(9'h0c3, 8, 1'b1, BC);
      rdchk("rx done", A_CTRL, C8 | 32'h5);
      rdchk("rx data", A_DATA, 32'hc3);
      $display("receive test done");
      bus(1'b1, A_PWR, 32'h40);
      bus(1'b1, A_CTRL, C8);
      u_station.send(9'h055, 8, 1'b0, BC);
      bus(1'b0, A_CTRL, 32'h0);
      check("fe set", rd & 32'hc0, 32'hc0);
      u_station.send(9'h0aa, 8, 1'b1, BC);
      bus(1'b0, A_CTRL, 32'h0);
      check("fe kept", rd & 32'h80, 32'h80);
      bus(1'b1, A_CTRL, C8);
      bus(1'b0, A_CTRL, 32'h0);
      check("fe cleared", rd & 32'hc0, 32'h40);
      bus(1'b1, A_PWR, 32'h0);
      $display("framing test done");
      bus(1'b1, A_STAT, 32'hf);
      bus(1'b1, A_CTRL, {24'h0, MODE_UART9_VAR, 6'h30});
      u_station.send(9'h153, 9, 1'b1, BC);
      rdchk("match", A_STAT, 32'ha);
      bus(1'b1, A_STAT, 32'hf);
      bus(1'b1, A_CTRL, {24'h0, MODE_UART9_VAR, 6'h30});
      u_station.send(9'h163, 9, 1'b1, BC);
      rdchk("no match", A_STAT, 32'h0);
      $display("address test done");
      report_and_stop;
   end
endmodule // test_serial_port_buffer_and_control
`default_nettype wire
